// >>> design/etr_parser.sv
// Transmit request frame parser with request buffer and status frame builder.

module etr_parser import etr_pkg::*; #(
  parameter int MAX_PAYLOAD_BYTES = 84
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic [7:0] max_hops_setting_in,
  input wire logic [7:0] default_tx_options_in,
  output logic req_valid_out,
  input wire logic req_ready_in,
  output logic [7:0] req_tag_out,
  output logic req_explicit_out,
  output logic [63:0] req_dst64_out,
  output logic [15:0] req_dst16_out,
  output logic [1:0] req_bcast_kind_out,
  output logic req_short_unknown_out,
  output logic [7:0] req_hops_out,
  output logic [7:0] req_options_out,
  output logic req_no_ack_out,
  output logic req_opt_error_out,
  output logic req_loopback_out,
  output logic req_devobj_out,
  output logic req_forward_out,
  output logic [15:0] req_payload_len_out,
  output logic [7:0] pay_byte_out,
  output logic pay_valid_out,
  input wire logic done_valid_in,
  input wire logic [7:0] done_tag_in,
  input wire logic done_explicit_in,
  input wire logic [15:0] done_short_in,
  input wire logic [7:0] done_status_in,
  output logic done_ready_out,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic drop_out
);
  localparam int BUF_W = 8 + 1 + 64 + 16 + 2 + 1 + 8 + 8 + 1 + 1 + 1 + 1 + 1 + 16;
  localparam logic [15:0] MAX_PAY = 16'(MAX_PAYLOAD_BYTES);
  localparam logic [3:0] STAT_LEN = 4'h9;

  etr_state_e state, next_state;
  logic [15:0] len, next_len;
  logic [15:0] pos, next_pos;
  logic [7:0] sum, next_sum;
  logic [7:0] kind, next_kind;
  logic [7:0] tag, next_tag;
  logic [63:0] dst64, next_dst64;
  logic [15:0] dst16, next_dst16, cluster, next_cluster, profile, next_profile;
  logic [7:0] src_ep, next_src_ep, dst_ep, next_dst_ep, radius, next_radius;
  logic [7:0] opts, next_opts;
  logic [3:0] sidx, next_sidx;
  logic [7:0] s_tag, next_s_tag, s_type, next_s_type, s_stat, next_s_stat;
  logic [15:0] s_short, next_s_short;
  logic [7:0] s_sum, next_s_sum;
  logic drop, next_drop;
  logic [7:0] pay_byte, next_pay_byte;
  logic pay_valid, next_pay_valid;
  logic [BUF_W-1:0] buf_mem [2];
  logic [BUF_W-1:0] in_word;
  logic wr_ptr, rd_ptr;
  logic [1:0] count;
  logic push, buf_ready;
  logic byte_take, expl;
  logic [15:0] ofs_radius, ofs_opts, ofs_pay, pay_len;
  logic [7:0] st_byte;

  assign expl = (kind == TYPE_TX_EXPLICIT);
  assign ofs_radius = expl ? OFS_RADIUS_X : OFS_RADIUS_P;
  assign ofs_opts = expl ? OFS_OPTS_X : OFS_OPTS_P;
  assign ofs_pay = expl ? OFS_PAY_X : OFS_PAY_P;
  // Payload length: frame body bytes past the fixed fields
  assign pay_len = len + OFS_TYPE - ofs_pay;
  assign rx_ready_out = (state != ETR_SEND) && (state != ETR_CSUM || buf_ready);
  assign byte_take = rx_valid_in && rx_ready_out;
  assign done_ready_out = (state == ETR_HUNT) && !rx_valid_in;

  // Frame walker next-state logic
  always_comb begin
    next_state = state;
    next_len = len;
    next_pos = pos;
    next_sum = sum;
    next_kind = kind;
    next_tag = tag;
    next_dst64 = dst64;
    next_dst16 = dst16;
    next_src_ep = src_ep;
    next_dst_ep = dst_ep;
    next_cluster = cluster;
    next_profile = profile;
    next_radius = radius;
    next_opts = opts;
    next_drop = 1'b0;
    next_pay_valid = 1'b0;
    next_pay_byte = pay_byte;
    push = 1'b0;
    case (state)
      ETR_HUNT: begin
        next_pos = OFS_LEN_HI;
        next_sum = 8'h00;
        if (byte_take && rx_byte_in == START_DELIM) begin
          next_state = ETR_BODY;
        end else if (done_valid_in && done_ready_out && done_tag_in != 8'h00) begin
          next_state = ETR_SEND;
        end
      end
      ETR_BODY: if (byte_take) begin
        next_pos = pos + 16'h0001;
        if (pos >= OFS_TYPE) next_sum = sum + rx_byte_in;
        if (pos == OFS_LEN_HI) next_len = {rx_byte_in, len[7:0]};
        if (pos == OFS_LEN_LO) next_len = {len[15:8], rx_byte_in};
        if (pos == OFS_TYPE) next_kind = rx_byte_in;
        if (pos == OFS_TAG) next_tag = rx_byte_in;
        if (pos >= OFS_DST64 && pos < OFS_DST16) next_dst64 = {dst64[55:0], rx_byte_in};
        if (pos == OFS_DST16 || pos == OFS_DST16 + 16'h0001) begin
          next_dst16 = {dst16[7:0], rx_byte_in};
        end
        if (expl && pos == OFS_SRC_EP) next_src_ep = rx_byte_in;
        if (expl && pos == OFS_DST_EP) next_dst_ep = rx_byte_in;
        if (expl && (pos == OFS_CLUSTER || pos == OFS_CLUSTER + 16'h0001)) begin
          next_cluster = {cluster[7:0], rx_byte_in};
        end
        if (expl && (pos == OFS_PROFILE || pos == OFS_PROFILE + 16'h0001)) begin
          next_profile = {profile[7:0], rx_byte_in};
        end
        if (pos == ofs_radius) next_radius = rx_byte_in;
        if (pos == ofs_opts) next_opts = rx_byte_in;
        // payload bytes stream out as they pass
        if (pos >= ofs_pay && pos > OFS_LEN_LO) begin
          next_pay_valid = 1'b1;
          next_pay_byte = rx_byte_in;
        end
        if (pos > OFS_LEN_LO && pos == len + OFS_LEN_LO) next_state = ETR_CSUM;
        if (pos == OFS_LEN_LO && {len[15:8], rx_byte_in} == 16'h0000) next_state = ETR_CSUM;
      end
      ETR_CSUM: if (byte_take) begin
        next_state = ETR_HUNT;
        // bad checksum, short length, unknown kind or oversize is dropped
        if (rx_byte_in != CSUM_BASE - sum || len < ofs_pay - OFS_TYPE ||
            (kind != TYPE_TX_EXPLICIT && kind != TYPE_TX_PLAIN) || pay_len > MAX_PAY) begin
          next_drop = 1'b1;
        end else begin
          push = 1'b1;
        end
      end
      ETR_SEND: if (tx_ready_in && sidx == STAT_LEN) next_state = ETR_HUNT;
      default: next_state = ETR_HUNT;
    endcase
  end

  // Frame walker registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ETR_HUNT;
      len <= 16'h0000;
      pos <= 16'h0000;
      sum <= 8'h00;
      kind <= 8'h00;
      tag <= 8'h00;
      dst64 <= 64'h0;
      dst16 <= 16'h0000;
      src_ep <= 8'h00;
      dst_ep <= 8'h00;
      cluster <= 16'h0000;
      profile <= 16'h0000;
      radius <= 8'h00;
      opts <= 8'h00;
      drop <= 1'b0;
      pay_valid <= 1'b0;
      pay_byte <= 8'h00;
    end else begin
      state <= next_state;
      len <= next_len;
      pos <= next_pos;
      sum <= next_sum;
      kind <= next_kind;
      tag <= next_tag;
      dst64 <= next_dst64;
      dst16 <= next_dst16;
      src_ep <= next_src_ep;
      dst_ep <= next_dst_ep;
      cluster <= next_cluster;
      profile <= next_profile;
      radius <= next_radius;
      opts <= next_opts;
      drop <= next_drop;
      pay_valid <= next_pay_valid;
      pay_byte <= next_pay_byte;
    end
  end
  assign drop_out = drop;
  assign pay_valid_out = pay_valid;
  assign pay_byte_out = pay_byte;

  // Decoded request word for the buffer
  always_comb begin
    logic [1:0] bk;
    logic [7:0] eo;
    bk = 2'd0;
    eo = 8'h00;
    if (dst16 == SHORT_BC_ROUTERS) bk = 2'd1;
    else if (dst16 == SHORT_BC_AWAKE) bk = 2'd2;
    else if (dst16 == SHORT_BC_ALL || dst64 == LONG_BCAST) bk = 2'd3;
    // zero options take the stored default
    eo = (opts == 8'h00) ? default_tx_options_in : opts;
    in_word = {tag, expl, dst64, dst16, bk, (dst16 == SHORT_UNKNOWN),
      // zero radius takes the maximum-hops setting
      (radius == 8'h00) ? max_hops_setting_in : radius,
      eo,
      // no-ack bit and illegal option bits
      (eo & OPT_NO_ACK) != 8'h00, (eo & ~OPT_LEGAL) != 8'h00,
      // loopback cluster on the data endpoint
      expl && dst_ep == EP_DATA && cluster == CL_LOOPBACK,
      expl && dst_ep == EP_DEVOBJ,
      // foreign profiles go to the host
      expl && profile != PROF_NATIVE && profile != PROF_ZDP,
      pay_len};
  end

  // Two-entry request buffer
  assign buf_ready = (count != 2'd2);
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (req_valid_out && req_ready_in) rd_ptr <= ~rd_ptr;
      count <= count + 2'(push) - 2'(req_valid_out && req_ready_in);
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) buf_mem[wr_ptr] <= in_word;
  end
  assign req_valid_out = (count != 2'd0);
  assign {req_tag_out, req_explicit_out, req_dst64_out, req_dst16_out, req_bcast_kind_out,
    req_short_unknown_out, req_hops_out, req_options_out, req_no_ack_out, req_opt_error_out,
    req_loopback_out, req_devobj_out, req_forward_out, req_payload_len_out} = buf_mem[rd_ptr];

  // Status frame builder: 7E, length, type, tag, short, status, delivery, checksum
  always_comb begin
    next_sidx = sidx;
    next_s_tag = s_tag;
    next_s_type = s_type;
    next_s_short = s_short;
    next_s_stat = s_stat;
    next_s_sum = s_sum;
    if (state == ETR_HUNT && next_state == ETR_SEND) begin
      next_sidx = 4'h0;
      next_s_tag = done_tag_in;
      next_s_type = done_explicit_in ? TYPE_STAT_EXT : TYPE_STAT_PLAIN;
      next_s_short = done_short_in;
      next_s_stat = done_status_in;
      next_s_sum = 8'h00;
    end else if (state == ETR_SEND && tx_ready_in) begin
      next_sidx = sidx + 4'h1;
      if (sidx >= 4'h3) next_s_sum = s_sum + st_byte;
    end
  end
  always_comb begin
    st_byte = 8'h00;
    case (sidx)
      4'h0: st_byte = START_DELIM;
      4'h2: st_byte = 8'h06;
      4'h3: st_byte = s_type;
      4'h4: st_byte = s_tag;
      4'h5: st_byte = s_short[15:8];
      4'h6: st_byte = s_short[7:0];
      4'h7: st_byte = s_stat;
      4'h8: st_byte = DELIV_OK;
      4'h9: st_byte = CSUM_BASE - s_sum;
      default: st_byte = 8'h00;
    endcase
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sidx <= 4'h0;
      s_tag <= 8'h00;
      s_type <= 8'h00;
      s_short <= 16'h0000;
      s_stat <= 8'h00;
      s_sum <= 8'h00;
    end else begin
      sidx <= next_sidx;
      s_tag <= next_s_tag;
      s_type <= next_s_type;
      s_short <= next_s_short;
      s_stat <= next_s_stat;
      s_sum <= next_s_sum;
    end
  end
  assign tx_valid_out = (state == ETR_SEND);
  assign tx_byte_out = st_byte;

  property p_drop_no_push;
    @(posedge clk_in) disable iff (sys_rst_in) drop |-> $past(state) == ETR_CSUM && !$past(push);
  endproperty
  a_drop_no_push: assert property (p_drop_no_push) else $error("drop with push");
  property p_stat_type;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(state == ETR_SEND) |->
        s_type == ($past(done_explicit_in) ? TYPE_STAT_EXT : TYPE_STAT_PLAIN);
  endproperty
  a_stat_type: assert property (p_stat_type) else $error("bad status type");
  property p_zero_tag;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state == ETR_HUNT && done_valid_in && done_tag_in == 8'h00) |=> state != ETR_SEND;
  endproperty
  a_zero_tag: assert property (p_zero_tag) else $error("zero tag answered");
  property p_no_zero_tag;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state == ETR_SEND && sidx == 4'h4) |-> s_tag != 8'h00;
  endproperty
  a_no_zero_tag: assert property (p_no_zero_tag) else $error("status with zero tag");
  property p_buf_bound;
    @(posedge clk_in) disable iff (sys_rst_in) push |-> count != 2'd2;
  endproperty
  a_buf_bound: assert property (p_buf_bound) else $error("buffer overflow");
  property p_stat_len;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state == ETR_SEND && sidx == 4'h9 && tx_ready_in) |=> state == ETR_HUNT;
  endproperty
  a_stat_len: assert property (p_stat_len) else $error("status frame overrun");
  property p_push_queued;
    @(posedge clk_in) disable iff (sys_rst_in) push |=> req_valid_out;
  endproperty
  a_push_queued: assert property (p_push_queued) else $error("request lost");
  property p_short_carry;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(state == ETR_SEND) |-> s_short == $past(done_short_in);
  endproperty
  a_short_carry: assert property (p_short_carry) else $error("short address lost");
endmodule

// >>> design/etr_pkg.sv
// Package for the transmit request frame parser: codes, offsets and field values.
package etr_pkg;
  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] TYPE_TX_PLAIN = 8'h10;
  localparam logic [7:0] TYPE_TX_EXPLICIT = 8'h11;
  localparam logic [7:0] TYPE_STAT_PLAIN = 8'h89;
  localparam logic [7:0] TYPE_STAT_EXT = 8'h8b;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  // Byte offsets within a frame
  localparam logic [15:0] OFS_LEN_HI = 16'h0001;
  localparam logic [15:0] OFS_LEN_LO = 16'h0002;
  localparam logic [15:0] OFS_TYPE = 16'h0003;
  localparam logic [15:0] OFS_TAG = 16'h0004;
  localparam logic [15:0] OFS_DST64 = 16'h0005;
  localparam logic [15:0] OFS_DST16 = 16'h000d;
  localparam logic [15:0] OFS_SRC_EP = 16'h000f;
  localparam logic [15:0] OFS_DST_EP = 16'h0010;
  localparam logic [15:0] OFS_CLUSTER = 16'h0011;
  localparam logic [15:0] OFS_PROFILE = 16'h0013;
  localparam logic [15:0] OFS_RADIUS_X = 16'h0015;
  localparam logic [15:0] OFS_OPTS_X = 16'h0016;
  localparam logic [15:0] OFS_PAY_X = 16'h0017;
  // Plain request has no endpoint, cluster or profile fields
  localparam logic [15:0] OFS_RADIUS_P = 16'h000f;
  localparam logic [15:0] OFS_OPTS_P = 16'h0010;
  localparam logic [15:0] OFS_PAY_P = 16'h0011;
  // Reserved address, endpoint, cluster, profile and option values
  localparam logic [15:0] SHORT_UNKNOWN = 16'hfffe;
  localparam logic [15:0] SHORT_BC_ROUTERS = 16'hfffc;
  localparam logic [15:0] SHORT_BC_AWAKE = 16'hfffd;
  localparam logic [15:0] SHORT_BC_ALL = 16'hffff;
  localparam logic [15:0] SHORT_COORD = 16'h0000;
  localparam logic [63:0] LONG_BCAST = 64'h0000_0000_0000_ffff;
  localparam logic [63:0] LONG_COORD = 64'h0000_0000_0000_0000;
  localparam logic [7:0] EP_DATA = 8'he8;
  localparam logic [7:0] EP_DEVOBJ = 8'he6;
  localparam logic [15:0] CL_TRANSPARENT = 16'h0011;
  localparam logic [15:0] CL_LOOPBACK = 16'h0012;
  localparam logic [15:0] PROF_NATIVE = 16'hc105;
  localparam logic [15:0] PROF_ZDP = 16'h0000;
  localparam logic [7:0] OPT_NO_ACK = 8'h01;
  localparam logic [7:0] OPT_RESERVED = 8'h02;
  localparam logic [7:0] OPT_LEGAL = 8'h7d;
  // Status delivery codes used on the status port
  localparam logic [7:0] DELIV_OK = 8'h00;
  typedef enum logic [3:0] {
    ETR_HUNT = 4'b0001,
    ETR_BODY = 4'b0010,
    ETR_CSUM = 4'b0100,
    ETR_SEND = 4'b1000
  } etr_state_e;
endpackage

// >>> sim/etr_host_model.sv
// Host side model: feeds request frames and takes status frame bytes.
module etr_host_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic slow = 1'b0;

  // Idle levels at time zero
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  // One byte held until ready is sampled high; line inverted once released
  task automatic send(input logic [7:0] f[$]);
    @(posedge clk_in);
    foreach (f[i]) begin
      rx_byte_out <= f[i];
      rx_valid_out <= 1'b1;
      @(posedge clk_in);
      while (rx_ready_in !== 1'b1) @(posedge clk_in);
    end
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~f[f.size()-1];
  endtask

  // Status bytes collected; slow mode stalls at random to test holding
  always @(posedge clk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) got.push_back(tx_byte_in);
    if (sys_rst_in) tx_ready_out <= 1'b0;
    else tx_ready_out <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the transmit request frame parser.
module tb_top import etr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAXP = 8;
  typedef logic [7:0] etr_bytes_t[$];
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] rx_byte, tx_byte, max_hops, def_opts, done_tag, done_status, pay_byte;
  logic rx_valid, rx_ready, req_valid, req_ready, req_explicit, req_short_unknown;
  logic req_no_ack, req_opt_error, req_loopback, req_devobj, req_forward, pay_valid;
  logic done_valid, done_explicit, done_ready, tx_valid, tx_ready, drop;
  logic [7:0] req_tag, req_hops, req_options;
  logic [63:0] req_dst64;
  logic [15:0] req_dst16, req_payload_len, done_short;
  logic [1:0] req_bcast_kind;
  int n_errors = 0;
  int comparisons = 0;
  int n_drop = 0;
  logic [7:0] pay_seen[$];
  logic [7:0] pay_exp[$];
  logic t_x;
  logic [7:0] t_tag, t_dep, t_rad, t_opt;
  logic [63:0] t_d64;
  logic [15:0] t_d16, t_cl, t_prof;
  logic [15:0] d16s[6] = '{16'hfffc, 16'hfffd, 16'hffff, 16'h1234, 16'h0000, 16'hfffe};
  logic [7:0] optv[6] = '{8'h01, 8'h02, 8'h40, 8'h00, 8'h80, 8'h05};
  logic [15:0] profs[3] = '{16'hc105, 16'h0000, 16'h0104};

  always #2.5 clk_in = ~clk_in;

  etr_parser #(.MAX_PAYLOAD_BYTES(MAXP)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
    .max_hops_setting_in(max_hops), .default_tx_options_in(def_opts),
    .req_valid_out(req_valid), .req_ready_in(req_ready), .req_tag_out(req_tag),
    .req_explicit_out(req_explicit), .req_dst64_out(req_dst64), .req_dst16_out(req_dst16),
    .req_bcast_kind_out(req_bcast_kind), .req_short_unknown_out(req_short_unknown),
    .req_hops_out(req_hops), .req_options_out(req_options), .req_no_ack_out(req_no_ack),
    .req_opt_error_out(req_opt_error), .req_loopback_out(req_loopback),
    .req_devobj_out(req_devobj), .req_forward_out(req_forward),
    .req_payload_len_out(req_payload_len), .pay_byte_out(pay_byte), .pay_valid_out(pay_valid),
    .done_valid_in(done_valid), .done_tag_in(done_tag), .done_explicit_in(done_explicit),
    .done_short_in(done_short), .done_status_in(done_status), .done_ready_out(done_ready),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .drop_out(drop));

  etr_host_model host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .tx_byte_in(tx_byte),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));

  // Payload pulses and drop pulses gathered for later comparison
  always @(posedge clk_in) begin
    if (pay_valid === 1'b1) pay_seen.push_back(pay_byte);
    if (drop === 1'b1) n_drop++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic etr_bytes_t framed(input etr_bytes_t b, input logic [7:0] flip);
    etr_bytes_t f;
    logic [15:0] n;
    logic [7:0] s;
    n = 16'(b.size());
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    f = {START_DELIM, n[15:8], n[7:0]};
    f = {f, b};
    f.push_back((CSUM_BASE - s) ^ flip);
    return f;
  endfunction

  function automatic etr_bytes_t body_of(input int np);
    etr_bytes_t b;
    b = {t_x ? TYPE_TX_EXPLICIT : TYPE_TX_PLAIN, t_tag};
    for (int i = 7; i >= 0; i--) b.push_back(t_d64[i*8 +: 8]);
    b = {b, t_d16[15:8], t_d16[7:0]};
    if (t_x) b = {b, EP_DATA, t_dep, t_cl[15:8], t_cl[7:0], t_prof[15:8], t_prof[7:0]};
    b = {b, t_rad, t_opt};
    pay_exp = {};
    repeat (np) pay_exp.push_back(8'($urandom));
    return {b, pay_exp};
  endfunction

  task automatic pick(input logic x, input logic [15:0] d16, input logic [7:0] opt);
    t_x = x;
    t_tag = 8'($urandom_range(1, 255));
    t_d64 = {$urandom, $urandom};
    t_d16 = d16;
    t_rad = 8'($urandom_range(0, 3));
    t_opt = opt;
    t_dep = EP_DATA;
    t_cl = CL_TRANSPARENT;
    t_prof = PROF_NATIVE;
  endtask

  task automatic send_req(input int np, input logic [7:0] flip);
    pay_seen = {};
    host.send(framed(body_of(np), flip));
  endtask

  // Waits for the decoded request, compares it and pops it
  task automatic take_req();
    logic [7:0] opts;
    logic [1:0] kind;
    int k;
    opts = (t_opt == 8'h00) ? def_opts : t_opt;
    kind = (t_d16 == SHORT_BC_ROUTERS) ? 2'h1 : (t_d16 == SHORT_BC_AWAKE) ? 2'h2 :
      (t_d16 == SHORT_BC_ALL || t_d64 == LONG_BCAST) ? 2'h3 : 2'h0;
    k = 0;
    do begin @(posedge clk_in); k++; end while (req_valid !== 1'b1 && k < 400);
    check(req_valid, 1'b1);
    check(req_tag, t_tag);
    check(req_explicit, t_x);
    check(req_dst64, t_d64);
    check(req_dst16, t_d16);
    check(req_bcast_kind, kind);
    check(req_short_unknown, t_d16 == SHORT_UNKNOWN);
    check(req_hops, (t_rad == 8'h00) ? max_hops : t_rad);
    check(req_options, opts);
    check(req_no_ack, (opts & OPT_NO_ACK) != 8'h00);
    check(req_opt_error, (opts & ~OPT_LEGAL) != 8'h00);
    check(req_loopback, t_x && t_dep == EP_DATA && t_cl == CL_LOOPBACK);
    check(req_devobj, t_x && t_dep == EP_DEVOBJ);
    check(req_forward, t_x && t_prof != PROF_NATIVE && t_prof != PROF_ZDP);
    check(req_payload_len, 16'(pay_exp.size()));
    check(64'(pay_seen.size()), 64'(pay_exp.size()));
    foreach (pay_exp[i]) if (i < pay_seen.size()) check(pay_seen[i], pay_exp[i]);
    req_ready <= 1'b1;
    @(posedge clk_in);
    req_ready <= 1'b0;
  endtask

  // Hands an outcome in and expects the status frame, or none for tag zero
  task automatic report(input logic [7:0] st);
    etr_bytes_t e;
    logic [15:0] sh;
    int k;
    sh = 16'($urandom);
    host.got = {};
    done_valid <= 1'b1;
    done_tag <= t_tag;
    done_explicit <= t_x;
    done_short <= sh;
    done_status <= st;
    k = 0;
    do begin @(posedge clk_in); k++; end while (done_ready !== 1'b1 && k < 100);
    check(done_ready, 1'b1);
    done_valid <= 1'b0;
    e = framed({t_x ? TYPE_STAT_EXT : TYPE_STAT_PLAIN, t_tag, sh[15:8], sh[7:0], st, 8'h00},
      8'h00);
    if (t_tag == 8'h00) e = {};
    k = 0;
    while (host.got.size() < 10 && k < 200) begin @(posedge clk_in); k++; end
    check(64'(host.got.size()), 64'(e.size()));
    foreach (e[i]) if (i < host.got.size()) check(host.got[i], e[i]);
  endtask

  // A refused frame gives one drop pulse and no request
  task automatic drop_case(input etr_bytes_t f);
    int n;
    n = n_drop;
    host.send(f);
    repeat (20) @(posedge clk_in);
    check(64'(n_drop - n), 64'h1);
    check(req_valid, 1'b0);
  endtask

  initial begin
    void'($urandom(57));
    req_ready = 1'b0;
    done_valid = 1'b0;
    done_tag = 8'h00;
    done_explicit = 1'b0;
    done_short = 16'h0000;
    done_status = 8'h00;
    max_hops = 8'($urandom_range(1, 255));
    def_opts = 8'($urandom_range(1, 255));
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // Explicit unicast, unknown short address, full payload, slow host
    host.slow = 1'b1;
    pick(1'b1, SHORT_UNKNOWN, 8'h00);
    send_req(MAXP, 8'h00);
    take_req();
    report(DELIV_OK);
    host.slow = 1'b0;
    $display("test explicit_unicast done");
    // Reserved addresses, endpoints, clusters and profiles
    for (int i = 0; i < 6; i++) begin
      pick(1'(i % 2), d16s[i], optv[i]);
      if (i == 1) t_dep = EP_DEVOBJ;
      if (i == 3) t_cl = CL_LOOPBACK;
      if (i == 3) t_d64 = 64'hffff_ffff_ffff_ffff;
      if (i == 4) t_d64 = LONG_COORD;
      if (i == 5) t_d64 = LONG_BCAST;
      t_prof = profs[i % 3];
      send_req(i, 8'h00);
      take_req();
      report(8'($urandom));
    end
    $display("test address_table done");
    // Tag zero suppresses the status frame
    pick(1'b0, 16'h1234, 8'h01);
    t_tag = 8'h00;
    send_req(3, 8'h00);
    take_req();
    report(DELIV_OK);
    $display("test zero_tag done");
    drop_case(framed(body_of(2), 8'h01));
    drop_case(framed(body_of(MAXP + 1), 8'h00));
    // Short length and unknown kind are refused as well
    drop_case(framed({TYPE_TX_PLAIN, 8'h05}, 8'h00));
    drop_case(framed({8'h12, body_of(0)}, 8'h00));
    $display("test drops done");
    // Two-entry buffer fills, then input stalls on the third checksum
    pick(1'b0, SHORT_UNKNOWN, 8'h00);
    fork
      repeat (3) send_req(0, 8'h00);
    join_none
    repeat (300) @(posedge clk_in);
    check(rx_ready, 1'b0);
    check(req_valid, 1'b1);
    repeat (3) take_req();
    $display("test buffer_stall done");
    tally_and_finish();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    tally_and_finish();
  end
endmodule
